/* hdl/pfs_defines.svh */
/*
  Constants of the port 0 pin function select block: register indices,
  field positions, write masks, reset values and sizes.
  Assumes it is included by its bare name before the package and module.
*/
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PFS_NPINS 7
`define PFS_NIRQ 6

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PFS_IDX_PIN0 30'h0000a050
`define PFS_IDX_PIN1 30'h0000a051
`define PFS_IDX_PIN2 30'h0000a052
`define PFS_IDX_PIN3 30'h0000a053
`define PFS_IDX_PIN4 30'h0000a054
`define PFS_IDX_PIN5 30'h0000a055
`define PFS_IDX_PIN6 30'h0000a056
`define PFS_IDX_STATUS 30'h0000a0e0
`define PFS_IDX_MASK 30'h0000a0e1

// ****************************************************************
// Field positions of a select register
// ****************************************************************
`define PFS_GPIO_BIT 0
`define PFS_IRQ_BIT 1
`define PFS_TX_BIT 1
`define PFS_ANALOG_BIT 2
`define PFS_EDGE_BIT 3

// ****************************************************************
// Write masks and reset values
// ****************************************************************
`define PFS_SEL_MASK 8'h0f
`define PFS_SEL6_MASK 8'h07
`define PFS_SEL_RESET 8'h00
`define PFS_IRQ_RESET 6'h00
`define PFS_PAD_OE_N_RESET 7'h7f

`endif

/* hdl/pfs_pkg.sv */
/*
  Types of the port 0 pin function select block.
  Assumes pfs_defines.svh is compiled alongside.
*/
`default_nettype none

package pfs_pkg;
  typedef logic [7:0] pfs_sel_t;
  typedef logic [5:0] pfs_irq_t;
  typedef logic [6:0] pfs_pins_t;
endpackage : pfs_pkg

`default_nettype wire

/* hdl/pfs_top.sv */
/*
  Port 0 pin function select: seven select registers on a classic
  Wishbone slave that route pads 0 to 6 to general I/O, pin interrupt
  lines, analog converter inputs or the serial port 0 transmit line,
  plus a sticky interrupt status and mask for the pin interrupt events.
  Assumes one clock, a synchronous active-high reset, asynchronous pad
  inputs, and port logic and serial port on the same clock.

  // Operation
  // - Pin 0 select at 0xA050: edge bit3, analog A1 bit2, irq bit1, io bit0.
  // - Pin 1 select at 0xA051, same layout, irq line 1.1 or A2.
  // - Pin 2 select at 0xA052, same layout, irq line 1.2 or B1.
  // - Pin 3 select at 0xA053, same layout, irq line 1.3 or B2.
  // - Pin 4 select at 0xA054, same layout, irq line 1.4 or C1.
  // - Pin 5 select at 0xA055, same layout, irq line 1.5 or C2.
  // - Pin 6 select at 0xA056: analog D1 bit2, transmit bit1, io bit0.
  // - Edge bit one triggers on rising pin edge, zero on falling.
  // - Edge bit acts only while the pin interrupt route is set.
  // - Every select register reads 0x00 after reset.
  // - Select registers read back the implemented bits as written.
  // - General I/O route connects the pin to the port logic.
  // - Pin interrupt route connects the pin to its interrupt line.
  // - Pin 6 bit 1 drives the pin from serial port 0 transmit.
*/
// Design decision made here: the Wishbone interface to the registers.
`include "pfs_defines.svh"
`default_nettype none

module pfs_top
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pads
  input wire logic [6:0] pad_in_i,
  output logic [6:0] pad_out_o,
  output logic [6:0] pad_oe_n_o,
  // General I/O port logic
  input wire logic [6:0] gpio_out_i,
  input wire logic [6:0] gpio_oe_i,
  output logic [6:0] gpio_in_o,
  // Serial port 0
  input wire logic serial0_transmit_i,
  // Pin interrupt lines
  output logic [5:0] pint_line_o,
  output logic [5:0] pint_trig_o,
  // Analog converter channel switches
  output logic [6:0] analog_route_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  pfs_sel_t sel_reg [0:6];
  pfs_sel_t sel_next [0:6];
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  wire req = wb_cyc_i & wb_stb_i;
  // Writes commit at the edge where the master sees ack high.
  wire wr_en = req & ack_reg & wb_we_i & wb_sel_i[0];
  wire [29:0] word_idx = wb_adr_i[31:2];
  wire [6:0] sel_hit;
  wire stat_hit = word_idx == `PFS_IDX_STATUS;
  wire mask_hit = word_idx == `PFS_IDX_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < `PFS_NPINS; gi++) begin : g_sel
      wire pfs_sel_t wmask = (gi == 6) ? `PFS_SEL6_MASK : `PFS_SEL_MASK;
      assign sel_hit[gi] = word_idx == (`PFS_IDX_PIN0 + 30'(gi));
      // Only the implemented bits are stored; the rest read zero.
      assign sel_next[gi] = (wr_en & sel_hit[gi]) ?
                            (wb_dat_i[7:0] & wmask) : sel_reg[gi];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sel_reg[gi] <= `PFS_SEL_RESET;
        end else begin
          sel_reg[gi] <= sel_next[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Route decode
  // ****************************************************************
  // If software sets several bits anyway, general I/O wins, then the
  // interrupt or transmit route, then the analog switch.
  wire pfs_pins_t general_io_route;
  wire pfs_pins_t analog_route;
  wire pfs_irq_t pin_irq_route;
  wire pfs_irq_t irq_edge_select;
  wire serial0_transmit_route =
    sel_reg[6][`PFS_TX_BIT] & ~sel_reg[6][`PFS_GPIO_BIT];

  generate
    for (gi = 0; gi < `PFS_NPINS; gi++) begin : g_route
      wire busy;
      assign general_io_route[gi] = sel_reg[gi][`PFS_GPIO_BIT];
      if (gi < `PFS_NIRQ) begin : g_irq
        assign pin_irq_route[gi] = sel_reg[gi][`PFS_IRQ_BIT] &
                                   ~general_io_route[gi];
        assign irq_edge_select[gi] = sel_reg[gi][`PFS_EDGE_BIT];
        assign busy = general_io_route[gi] | pin_irq_route[gi];
      end else begin : g_tx
        assign busy = general_io_route[gi] | serial0_transmit_route;
      end
      // The pad analog connect bit lives in pad configuration.
      assign analog_route[gi] = sel_reg[gi][`PFS_ANALOG_BIT] & ~busy;
    end
  endgenerate

  // ****************************************************************
  // Pad input synchroniser and edge detection
  // ****************************************************************
  pfs_pins_t sync1_reg;
  pfs_pins_t sync2_reg;
  pfs_pins_t prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      prev_reg <= 7'h00;
    end else begin
      sync1_reg <= pad_in_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire pfs_pins_t rise = sync2_reg & ~prev_reg;
  wire pfs_pins_t fall = ~sync2_reg & prev_reg;
  // Edge choice only matters behind an active interrupt route.
  wire pfs_irq_t trig_next = pin_irq_route &
    ((irq_edge_select & rise[5:0]) |
     (~irq_edge_select & fall[5:0]));
  wire pfs_irq_t line_next = pin_irq_route & sync2_reg[5:0];
  wire pfs_pins_t gpio_in_next = general_io_route & sync2_reg;

  // ****************************************************************
  // Pad drive
  // ****************************************************************
  wire pfs_pins_t drive_next = (general_io_route & gpio_oe_i) |
                               {serial0_transmit_route, 6'h00};
  wire pfs_pins_t out_next = (general_io_route & gpio_out_i) |
    {serial0_transmit_route & serial0_transmit_i, 6'h00};

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  pfs_irq_t stat_reg;
  pfs_irq_t mask_reg;
  wire pfs_irq_t stat_clr = (wr_en & stat_hit) ? wb_dat_i[5:0] : 6'h00;
  // A new event in the clearing cycle survives the clear.
  wire pfs_irq_t stat_next = (stat_reg & ~stat_clr) | trig_next;
  wire pfs_irq_t mask_next = (wr_en & mask_hit) ? wb_dat_i[5:0] : mask_reg;
  wire irq_next = |(stat_next & mask_next);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= `PFS_IRQ_RESET;
      mask_reg <= `PFS_IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_o <= irq_next;
    end
  end

  // ****************************************************************
  // Read mux and bus answer
  // ****************************************************************
  always_comb begin
    rd_data = 32'h00000000;
    for (int k = 0; k < `PFS_NPINS; k++) begin
      if (sel_hit[k]) begin
        rd_data[7:0] = sel_reg[k];
      end
    end
    if (stat_hit) begin
      rd_data[5:0] = stat_reg;
    end
    if (mask_hit) begin
      rd_data[5:0] = mask_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        dat_reg <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= 7'h00;
      pad_oe_n_o <= `PFS_PAD_OE_N_RESET;
      gpio_in_o <= 7'h00;
      pint_line_o <= 6'h00;
      pint_trig_o <= 6'h00;
      analog_route_o <= 7'h00;
    end else begin
      pad_out_o <= out_next;
      pad_oe_n_o <= ~drive_next;
      gpio_in_o <= gpio_in_next;
      pint_line_o <= line_next;
      pint_trig_o <= trig_next;
      analog_route_o <= analog_route;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_reset_zero;
    $fell(rst_i) |-> (sel_reg[0] == 8'h00) && (sel_reg[6] == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("select register not zero after reset");

  property p_write_pin0;
    wr_en && sel_hit[0] |=>
      sel_reg[0] == ($past(wb_dat_i[7:0]) & `PFS_SEL_MASK);
  endproperty
  a_write_pin0: assert property (p_write_pin0)
    else $error("pin 0 select did not take the write");

  property p_readback;
    req && !ack_reg && sel_hit[3] && !wb_we_i |=>
      wb_ack_o && wb_dat_o == {24'h000000, $past(sel_reg[3])};
  endproperty
  a_readback: assert property (p_readback)
    else $error("pin 3 select read back wrong");

  property p_pin6_upper;
    sel_reg[6][7:3] == 5'h00 && sel_reg[2][7:4] == 4'h0;
  endproperty
  a_pin6_upper: assert property (p_pin6_upper)
    else $error("unimplemented select bits set");

  property p_rise_trig;
    pin_irq_route[0] && irq_edge_select[0] && rise[0] |=> pint_trig_o[0];
  endproperty
  a_rise_trig: assert property (p_rise_trig)
    else $error("rising edge did not trigger");

  property p_fall_trig;
    pin_irq_route[1] && !irq_edge_select[1] && rise[1] |=> !pint_trig_o[1];
  endproperty
  a_fall_trig: assert property (p_fall_trig)
    else $error("rising edge triggered a falling-edge pin");

  property p_no_route_trig;
    !pin_irq_route[0] |=> !pint_trig_o[0] && !pint_line_o[0];
  endproperty
  a_no_route_trig: assert property (p_no_route_trig)
    else $error("interrupt fired without route");

  property p_gpio_conn;
    general_io_route[5] |=> gpio_in_o[5] == $past(sync2_reg[5]);
  endproperty
  a_gpio_conn: assert property (p_gpio_conn)
    else $error("general io input not connected");

  property p_tx_drive;
    sel_reg[6] == 8'h02 |=>
      !pad_oe_n_o[6] && pad_out_o[6] == $past(serial0_transmit_i);
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("pin 6 not driven by serial transmit");

  property p_idle_pin;
    sel_reg[2] == 8'h00 |=> pad_oe_n_o[2] && !gpio_in_o[2] &&
      !analog_route_o[2] && !pint_line_o[2];
  endproperty
  a_idle_pin: assert property (p_idle_pin)
    else $error("unrouted pin is connected");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_irq_level;
    irq_o == ((stat_reg & mask_reg) != 6'h00);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status and mask");

  property p_write_pin6;
    wr_en && sel_hit[6] |=>
      sel_reg[6] == ($past(wb_dat_i[7:0]) & `PFS_SEL6_MASK);
  endproperty
  a_write_pin6: assert property (p_write_pin6)
    else $error("pin 6 select did not take the write");

  property p_write_pin4;
    wr_en && sel_hit[4] |=>
      sel_reg[4] == ($past(wb_dat_i[7:0]) & `PFS_SEL_MASK);
  endproperty
  a_write_pin4: assert property (p_write_pin4)
    else $error("pin 4 select did not take the write");

  property p_fall_good;
    pin_irq_route[3] && !irq_edge_select[3] && fall[3] |=> pint_trig_o[3];
  endproperty
  a_fall_good: assert property (p_fall_good)
    else $error("falling edge did not trigger");

  property p_line_level;
    pin_irq_route[2] |=> pint_line_o[2] == $past(sync2_reg[2]);
  endproperty
  a_line_level: assert property (p_line_level)
    else $error("interrupt line does not follow the pin");

  property p_gpio_drive;
    general_io_route[3] |=> pad_oe_n_o[3] == ~$past(gpio_oe_i[3]) &&
      pad_out_o[3] == $past(gpio_out_i[3]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("general io does not drive the pad");

  property p_analog_pin5;
    sel_reg[5] == 8'h04 |=> analog_route_o[5];
  endproperty
  a_analog_pin5: assert property (p_analog_pin5)
    else $error("pin 5 analog switch not enabled");

  property p_status_set;
    trig_next != 6'h00 |=> (stat_reg & $past(trig_next)) == $past(trig_next);
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("pin event lost from status");

  property p_ack_answer;
    req && !ack_reg |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not answered in one cycle");

  c_tx: cover property (sel_reg[6] == 8'h02 && !pad_oe_n_o[6]);
  c_rise: cover property (pint_trig_o[0] && irq_edge_select[0]);
  c_irq: cover property ($rose(irq_o));
  c_write: cover property (wr_en && sel_hit[6]);

endmodule : pfs_top

`default_nettype wire

/* tb/pfs_pad_model.sv */
/*
  Pad model: resolves each pad level from the block's drive and an
  outside source. Assumes the bench supplies the outside level.
*/
`default_nettype none
module pfs_pad_model (
  // Block side
  input wire logic [6:0] pad_out_i,
  input wire logic [6:0] pad_oe_n_i,
  // Outside source
  input wire logic [6:0] ext_i,
  output logic [6:0] pad_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pad shows the block's value, a released one the outside.
  assign pad_in_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_i);
endmodule // pfs_pad_model
`default_nettype wire

/* tb/pfs_top_bench.sv */
/*
  Bench of the pin function select block: registers over Wishbone and
  routing of pads to port, interrupt, serial and analog functions.
  Assumes the pad model and the design files are compiled first.
*/
`include "pfs_defines.svh"
`default_nettype none
module pfs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic tx = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic [6:0] gout = 7'h00;
  logic [6:0] goe = 7'h00;
  logic [6:0] ext = 7'h00;
  logic ack, irq;
  logic [31:0] rd, q;
  logic [6:0] pin, pout, poe_n, gin, ana;
  logic [5:0] line, trig;
  int errors = 0;
  int n_compared = 0;
  int h;
  pfs_top pfs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .pad_in_i(pin),
    .pad_out_o(pout), .pad_oe_n_o(poe_n), .gpio_out_i(gout),
    .gpio_oe_i(goe), .gpio_in_o(gin), .serial0_transmit_i(tx),
    .pint_line_o(line), .pint_trig_o(trig), .analog_route_o(ana),
    .irq_o(irq));
  pfs_pad_model pfs_pad_model_inst (.pad_out_i(pout), .pad_oe_n_i(poe_n),
    .ext_i(ext), .pad_in_o(pin));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One classic cycle; read data lands in q.
  task automatic bus(input logic w, input logic [29:0] idx,
                     input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    // Ack and read data are taken at the rising edge that shows ack high.
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      wrap_up();
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic count_trig(input int i);
    h = 0;
    repeat (10) begin
      @(negedge clk_i);
      if (trig[i] === 1'b1) h++;
    end
  endtask
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, `PFS_IDX_PIN0 + 30'(i), 32'h0);
      chk("select reset", q, 32'h0);
    end
    chk("pads released", {25'h0, poe_n}, 32'h7f);
    chk("idle routes", {gin, ana, line, trig, irq}, 32'h0);
  endtask
  task automatic t_regs();
    logic [31:0] e;
    for (int i = 0; i < 7; i++) begin
      e = (i == 6) ? 32'h01 : 32'h09;
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'hffff_fff9);
      bus(1'b0, `PFS_IDX_PIN0 + 30'(i), 32'h0);
      chk("select readback", q, e);
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'h0);
    end
    bus(1'b1, `PFS_IDX_PIN6 + 30'h1, 32'h1);
    bus(1'b0, `PFS_IDX_PIN6 + 30'h1, 32'h0);
    chk("unmapped read", q, 32'h0);
  endtask
  task automatic t_gpio();
    bus(1'b1, `PFS_IDX_PIN3, 32'h1);
    @(posedge clk_i);
    ext <= 7'h08;
    idle(5);
    chk("gpio input", {25'h0, gin}, 32'h08);
    chk("pad released", {25'h0, poe_n}, 32'h7f);
    @(posedge clk_i);
    goe <= 7'h08;
    idle(5);
    chk("pad drive", {30'h0, poe_n[3], pout[3]}, 32'h0);
    chk("gpio driven", {25'h0, gin}, 32'h0);
    @(posedge clk_i);
    gout <= 7'h08;
    idle(5);
    chk("pad out high", {25'h0, pout}, 32'h08);
    chk("gpio loop", {25'h0, gin}, 32'h08);
    bus(1'b1, `PFS_IDX_PIN3, 32'h0);
    idle(2);
    chk("unrouted", {gin, poe_n}, {7'h00, 7'h7f});
    @(posedge clk_i);
    ext <= 7'h00;
    goe <= 7'h00;
    gout <= 7'h00;
  endtask
  task automatic t_irq();
    logic r;
    for (int i = 0; i < 6; i++) begin
      r = (i % 2) == 0;
      @(posedge clk_i);
      ext[i] <= ~r;
      idle(5);
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), {28'h0, r, 3'b010});
      idle(2);
      @(posedge clk_i);
      ext[i] <= r;
      count_trig(i);
      chk("trigger pulses", 32'(h), 32'h1);
      chk("line level", {31'h0, line[i]}, {31'h0, r});
      bus(1'b0, `PFS_IDX_STATUS, 32'h0);
      chk("status", q, 32'h1 << i);
      if (i == 0) begin
        chk("masked irq", {31'h0, irq}, 32'h0);
        bus(1'b1, `PFS_IDX_MASK, 32'h3f);
        idle(2);
      end
      chk("irq raised", {31'h0, irq}, 32'h1);
      bus(1'b1, `PFS_IDX_STATUS, 32'h1 << i);
      idle(2);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      @(posedge clk_i);
      ext[i] <= ~r;
      count_trig(i);
      chk("wrong edge", 32'(h), 32'h0);
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'h8);
      @(posedge clk_i);
      ext[i] <= r;
      count_trig(i);
      chk("edge unrouted", 32'(h), 32'h0);
      chk("line unrouted", {31'h0, line[i]}, 32'h0);
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'h0);
      @(posedge clk_i);
      ext[i] <= 1'b0;
    end
  endtask
  task automatic t_tx_analog();
    bus(1'b1, `PFS_IDX_PIN6, 32'h2);
    @(posedge clk_i);
    tx <= 1'b1;
    idle(2);
    chk("tx high", {30'h0, poe_n[6], pout[6]}, 32'h1);
    @(posedge clk_i);
    tx <= 1'b0;
    idle(2);
    chk("tx low", {30'h0, poe_n[6], pout[6]}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'h4);
      idle(2);
      chk("analog route", {25'h0, ana}, 32'h1 << i);
      bus(1'b1, `PFS_IDX_PIN0 + 30'(i), 32'h0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_gpio();
    t_irq();
    t_tx_analog();
    wrap_up();
  end
endmodule // pfs_top_bench
`default_nettype wire
